//--- rtl/instr_status_pkg.sv
// Shared constants and carriers for the instrument status and serial command block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package instr_status_pkg;

  // Status byte bit positions.
  localparam int SB_OPERATION_GROUP = 7;
  localparam int SB_RQS = 6;
  localparam int SB_ESB = 5;
  localparam int SB_RESP = 4;
  localparam int SB_QUESTIONABLE_GROUP = 3;
  localparam int SB_ERRQ = 2;
  localparam logic [7:0] SB_RESERVED_MASK = 8'h03;

  // Standard event bit positions.
  localparam int SE_PON = 7;
  localparam int SE_CMD = 5;
  localparam int SE_EXE = 4;
  localparam int SE_DEV = 3;
  localparam int SE_QRY = 2;
  localparam int SE_OPC = 0;
  localparam logic [7:0] SE_USED_MASK = 8'hBD;

  // Operation group bit positions.
  localparam int OP_CAL = 0;
  localparam int OP_SETTLE = 1;
  localparam int OP_MEAS = 4;
  localparam int OP_TEST = 8;
  localparam int OP_PROG = 14;
  localparam logic [15:0] OP_USED_MASK = 16'h4113;

  // Questionable group bit positions.
  localparam int QU_TIME = 2;
  localparam int QU_TEMP = 3;
  localparam int QU_CAL = 7;
  localparam int QU_PRES = 8;
  localparam int QU_WARN = 14;
  localparam logic [15:0] QU_USED_MASK = 16'h418C;

  // Register selectors on the register port.
  typedef enum logic [3:0] {
    REG_STATUS_BYTE, REG_SRE, REG_ESR, REG_ESE,
    REG_OPERATION_GROUP_COND, REG_OPERATION_EVENT, REG_OPERATION_ENABLE,
    REG_QUESTIONABLE_GROUP_COND, REG_QUESTIONABLE_EVENT, REG_QUESTIONABLE_ENABLE
  } reg_sel_e;

  // Serial control bytes.
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_EQUAL = 8'h3D;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_SEMI = 8'h3B;

  // Zero delay: seconds and the 1 ms tick that counts it.
  localparam int CLK_HZ = 100_000_000;
  localparam int ZERO_DELAY_S = 5;
  localparam int TICK_MS_CYCLES = CLK_HZ / 1000;
  localparam int ZERO_DELAY_MS = ZERO_DELAY_S * 1000;

  // Instrument condition inputs.
  typedef struct packed {
    logic calibrating;
    logic out_of_tol;
    logic measuring;
    logic self_test;
    logic prog_running;
    logic clock_unset;
    logic oven_bad;
    logic uncalibrated;
    logic overrange;
  } cond_s;

  // One-cycle event pulses from the command parser.
  typedef struct packed {
    logic cmd_err;
    logic exe_err;
    logic dev_err;
    logic opc;
    logic param_ignored;
  } evt_s;

endpackage : instr_status_pkg

//--- rtl/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come from a register.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic [AW-1:0] rd_next;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rd_next = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head word is presented from a register once stored.
  assign out_valid = (cnt_q != '0);
  always_ff @(posedge clk) begin
    if (rst) begin
      out_data <= '0;
    end else begin
      // A word written into the head slot comes straight from the input.
      // The memory only holds it after this edge, so reading it would be stale.
      out_data <= (push && (wr_q == rd_next)) ? in_data : mem[rd_next];
    end
  end

endmodule : byte_fifo

//--- rtl/instr_status.sv
// Status register model and serial line handling for the pressure controller.
// Assumes condition levels from the instrument and parser pulses on clk.
`timescale 1ns/10ps
module instr_status #(
  parameter int ZERO_DELAY_MS_P = instr_status_pkg::ZERO_DELAY_MS,
  parameter int TICK_CYCLES_P = instr_status_pkg::TICK_MS_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire instr_status_pkg::cond_s cond,
  input wire instr_status_pkg::evt_s evt,
  input wire logic resp_request,
  input wire logic err_queue_nonempty,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire instr_status_pkg::reg_sel_e reg_sel,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic srq,
  input wire logic legacy_mode,
  input wire logic addressing_en_set,
  output logic addressing_en,
  output logic remote_flag,
  input wire logic rx_pin_byte_valid,
  input wire logic [7:0] rx_pin_byte,
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  output logic cmd_eol,
  output logic cmd_standard,
  input wire logic [7:0] resp_byte,
  input wire logic resp_valid,
  input wire logic resp_last,
  output logic resp_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic zero_cmd,
  output logic zero_valve,
  output logic zero_sensor,
  input wire logic rate_cmd,
  input wire logic rate_negative,
  output logic overshoot_low
);
  import instr_status_pkg::*;

  logic [15:0] op_cond, qu_cond, op_prev_q, qu_prev_q;
  logic [15:0] op_evt_q, qu_evt_q, op_en_q, qu_en_q;
  logic [7:0] esr_q, ese_q, sre_q, stb;
  logic rd_op_evt, rd_qu_evt, rd_esr, resp_waiting_flag;
  logic [7:0] stb_prev_q;

  always_comb begin
    op_cond = '0;
    op_cond[OP_CAL] = cond.calibrating;
    op_cond[OP_SETTLE] = cond.out_of_tol;
    op_cond[OP_MEAS] = cond.measuring;
    op_cond[OP_TEST] = cond.self_test;
    op_cond[OP_PROG] = cond.prog_running;
  end

  always_comb begin
    qu_cond = '0;
    qu_cond[QU_TIME] = cond.clock_unset;
    qu_cond[QU_TEMP] = cond.oven_bad;
    qu_cond[QU_CAL] = cond.uncalibrated;
    qu_cond[QU_PRES] = cond.overrange;
  end

  assign rd_op_evt = reg_rd && (reg_sel == REG_OPERATION_EVENT);
  assign rd_qu_evt = reg_rd && (reg_sel == REG_QUESTIONABLE_EVENT);
  assign rd_esr = reg_rd && (reg_sel == REG_ESR);

  always_ff @(posedge clk) begin
    if (rst) begin
      op_prev_q <= '0;
      qu_prev_q <= '0;
    end else begin
      op_prev_q <= op_cond;
      qu_prev_q <= qu_cond;
    end
  end

  // change latch, set wins over read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      op_evt_q <= '0;
      qu_evt_q <= '0;
    end else begin
      op_evt_q <= ((rd_op_evt ? '0 : op_evt_q) | (op_cond ^ op_prev_q)) & OP_USED_MASK;
      qu_evt_q <= ((rd_qu_evt ? '0 : qu_evt_q) | (qu_cond ^ qu_prev_q)
                  | (16'(evt.param_ignored) << QU_WARN)) & QU_USED_MASK;
    end
  end

  logic [7:0] esr_set;
  always_comb begin
    esr_set = '0;
    esr_set[SE_CMD] = evt.cmd_err;
    esr_set[SE_EXE] = evt.exe_err;
    esr_set[SE_DEV] = evt.dev_err;
    esr_set[SE_OPC] = evt.opc;
    esr_set[SE_QRY] = resp_request && !resp_waiting_flag;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      esr_q <= 8'h80;
    end else begin
      esr_q <= ((rd_esr ? 8'h00 : esr_q) | esr_set) & SE_USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ese_q <= '0;
      sre_q <= '0;
      op_en_q <= '0;
      qu_en_q <= '0;
    end else if (reg_wr) begin
      unique case (reg_sel)
        REG_ESE: ese_q <= reg_wdata[7:0];
        REG_SRE: sre_q <= reg_wdata[7:0] & ~(8'h01 << SB_RQS);
        REG_OPERATION_ENABLE: op_en_q <= reg_wdata;
        REG_QUESTIONABLE_ENABLE: qu_en_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    stb = '0;
    stb[SB_OPERATION_GROUP] = |(op_evt_q & op_en_q);
    stb[SB_ESB] = |(esr_q & ese_q);
    stb[SB_RESP] = resp_waiting_flag;
    stb[SB_QUESTIONABLE_GROUP] = |(qu_evt_q & qu_en_q);
    stb[SB_ERRQ] = err_queue_nonempty;
    stb[SB_RQS] = srq;
  end

  // service request on rising enabled bit
  always_ff @(posedge clk) begin
    if (rst) begin
      stb_prev_q <= '0;
      srq <= 1'b0;
    end else begin
      stb_prev_q <= stb;
      if (|(stb & ~stb_prev_q & sre_q & ~SB_RESERVED_MASK)) begin
        srq <= 1'b1;
      end else if (!(|(stb & sre_q & ~(8'h01 << SB_RQS)))) begin
        srq <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_sel)
        REG_STATUS_BYTE: reg_rdata <= {8'h00, stb};
        REG_SRE: reg_rdata <= {8'h00, sre_q};
        REG_ESR: reg_rdata <= {8'h00, esr_q};
        REG_ESE: reg_rdata <= {8'h00, ese_q};
        REG_OPERATION_GROUP_COND: reg_rdata <= op_cond;
        REG_OPERATION_EVENT: reg_rdata <= op_evt_q;
        REG_OPERATION_ENABLE: reg_rdata <= op_en_q;
        REG_QUESTIONABLE_GROUP_COND: reg_rdata <= qu_cond;
        REG_QUESTIONABLE_EVENT: reg_rdata <= qu_evt_q;
        REG_QUESTIONABLE_ENABLE: reg_rdata <= qu_en_q;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Serial receive: three-stage pin synchroniser on the valid strobe.
  logic [2:0] rxv_sync_q;
  logic [7:0] rx_hold_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxv_sync_q <= '0;
      rx_hold_q <= '0;
    end else begin
      rxv_sync_q <= {rxv_sync_q[1:0], rx_pin_byte_valid};
      rx_hold_q <= rx_pin_byte;
    end
  end

  logic rx_new;
  logic rxv_last_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxv_last_q <= 1'b0;
    end else if (rxv_sync_q[1] == rxv_sync_q[2]) begin
      rxv_last_q <= rxv_sync_q[2];
    end
  end
  assign rx_new = (rxv_sync_q[1] == rxv_sync_q[2]) && rxv_sync_q[2] && !rxv_last_q;

  logic is_xoff, is_xon, is_etx, is_eol, is_sep, line_start_q, xoff_q;
  logic [7:0] folded;
  assign is_xoff = rx_hold_q == CH_XOFF;
  assign is_xon = rx_hold_q == CH_XON;
  assign is_etx = rx_hold_q == CH_ETX;
  assign is_eol = (rx_hold_q == CH_CR) || (rx_hold_q == CH_LF);
  assign is_sep = legacy_mode && !cmd_standard && ((rx_hold_q == CH_SPACE)
                  || (rx_hold_q == CH_EQUAL) || (rx_hold_q == CH_COMMA)
                  || (rx_hold_q == CH_SEMI) || (!line_start_q && rx_hold_q == CH_COLON));
  assign folded = (legacy_mode && rx_hold_q >= 8'h61 && rx_hold_q <= 8'h7A)
                  ? (rx_hold_q & 8'hDF) : rx_hold_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      xoff_q <= 1'b0;
    end else if (rx_new && is_xoff) begin
      xoff_q <= 1'b1;
    end else if (rx_new && (is_xon || is_etx)) begin
      xoff_q <= 1'b0;
    end
  end

  // interrupt byte flush and addressing off
  logic flush;
  assign flush = rx_new && is_etx;
  always_ff @(posedge clk) begin
    if (rst) begin
      addressing_en <= 1'b0;
    end else if (flush) begin
      addressing_en <= 1'b0;
    end else if (addressing_en_set) begin
      addressing_en <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line_start_q <= 1'b1;
      cmd_standard <= 1'b1;
    end else if (flush || (rx_new && is_eol)) begin
      line_start_q <= 1'b1;
    end else if (rx_new && !is_xoff && !is_xon) begin
      line_start_q <= 1'b0;
      if (line_start_q) begin
        cmd_standard <= !legacy_mode || (rx_hold_q == CH_COLON);
      end
    end
  end

  // commands pass without address when addressing is off
  logic rxf_in_valid, rxf_in_ready;
  assign rxf_in_valid = rx_new && !is_xoff && !is_xon && !is_etx && !is_sep;
  logic [8:0] rxf_out;
  logic rxf_out_valid;
  byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .in_data({is_eol, folded}),
    .in_valid(rxf_in_valid),
    .in_ready(rxf_in_ready),
    .out_data(rxf_out),
    .out_valid(rxf_out_valid),
    .out_ready(1'b1)
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_byte <= '0;
      cmd_eol <= 1'b0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= rxf_out_valid && !addressing_en;
      cmd_byte <= rxf_out[7:0];
      cmd_eol <= rxf_out[8];
    end
  end

  // responses close with CR then LF
  typedef enum {TX_DATA, TX_CR, TX_LF} tx_state_e;
  tx_state_e tx_st_q;
  logic [7:0] txf_in;
  logic txf_in_valid, txf_in_ready, txf_out_valid, txf_pop;
  always_comb begin
    txf_in = resp_byte;
    txf_in_valid = 1'b0;
    resp_ready = 1'b0;
    unique case (tx_st_q)
      TX_DATA: begin
        txf_in_valid = resp_valid;
        resp_ready = txf_in_ready;
      end
      TX_CR: begin
        txf_in = CH_CR;
        txf_in_valid = 1'b1;
      end
      TX_LF: begin
        txf_in = CH_LF;
        txf_in_valid = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      tx_st_q <= TX_DATA;
    end else if (txf_in_valid && txf_in_ready) begin
      unique case (tx_st_q)
        TX_DATA: tx_st_q <= resp_last ? TX_CR : TX_DATA;
        TX_CR: tx_st_q <= TX_LF;
        TX_LF: tx_st_q <= TX_DATA;
      endcase
    end
  end
  assign resp_waiting_flag = (tx_st_q != TX_DATA) || txf_out_valid || resp_valid;

  assign txf_pop = tx_ready && !xoff_q;
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .in_data(txf_in),
    .in_valid(txf_in_valid),
    .in_ready(txf_in_ready),
    .out_data(tx_byte),
    .out_valid(txf_out_valid),
    .out_ready(txf_pop)
  );
  assign tx_valid = txf_out_valid && !xoff_q;

  assign remote_flag = legacy_mode;

  // zero valve then delay then zero
  localparam int TW = $clog2(TICK_CYCLES_P + 1);
  localparam int MW = $clog2(ZERO_DELAY_MS_P + 1);
  logic [TW-1:0] tick_q;
  logic [MW-1:0] ms_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_valve <= 1'b0;
      zero_sensor <= 1'b0;
      tick_q <= '0;
      ms_q <= '0;
    end else begin
      zero_sensor <= 1'b0;
      if (zero_cmd && !zero_valve) begin
        zero_valve <= 1'b1;
        tick_q <= '0;
        ms_q <= '0;
      end else if (zero_valve) begin
        if (tick_q == TW'(TICK_CYCLES_P - 1)) begin
          tick_q <= '0;
          if (ms_q == MW'(ZERO_DELAY_MS_P - 1)) begin
            zero_valve <= 1'b0;
            zero_sensor <= 1'b1;
          end else begin
            ms_q <= ms_q + 1'b1;
          end
        end else begin
          tick_q <= tick_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overshoot_low <= 1'b1;
    end else if (rate_cmd) begin
      overshoot_low <= !rate_negative;
    end
  end

  property p_evt_clear_on_read;
    @(posedge clk) disable iff (rst)
      rd_op_evt && (op_cond == op_prev_q) |=> op_evt_q == '0;
  endproperty
  a_evt_clear_on_read: assert property (p_evt_clear_on_read) else $error("event not cleared");

  property p_summary;
    @(posedge clk) disable iff (rst) |(op_evt_q & op_en_q) |-> stb[SB_OPERATION_GROUP];
  endproperty
  a_summary: assert property (p_summary) else $error("summary missing");

  property p_srq;
    @(posedge clk) disable iff (rst)
      |(stb & ~stb_prev_q & sre_q & ~SB_RESERVED_MASK) |=> srq;
  endproperty
  a_srq: assert property (p_srq) else $error("service request missing");

  property p_stb_res;
    @(posedge clk) disable iff (rst) (stb & SB_RESERVED_MASK) == 8'h00;
  endproperty
  a_stb_res: assert property (p_stb_res) else $error("reserved status bits set");

  property p_esr_res;
    @(posedge clk) disable iff (rst) esr_q[6] == 1'b0 && esr_q[1] == 1'b0;
  endproperty
  a_esr_res: assert property (p_esr_res) else $error("reserved event bits set");

  property p_qerr;
    @(posedge clk) disable iff (rst) resp_request && !resp_waiting_flag |=> esr_q[SE_QRY];
  endproperty
  a_qerr: assert property (p_qerr) else $error("query error missing");

  property p_warn;
    @(posedge clk) disable iff (rst) evt.param_ignored |=> qu_evt_q[QU_WARN];
  endproperty
  a_warn: assert property (p_warn) else $error("warning bit missing");

  sequence s_xoff_seen;
    rx_new && is_xoff;
  endsequence
  property p_xoff;
    @(posedge clk) disable iff (rst) s_xoff_seen |=> !tx_valid;
  endproperty
  a_xoff: assert property (p_xoff) else $error("transmit after xoff");

  property p_flush;
    @(posedge clk) disable iff (rst) flush |=> !addressing_en && !txf_out_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("flush incomplete");

  property p_rate;
    @(posedge clk) disable iff (rst) rate_cmd |=> overshoot_low == !$past(rate_negative);
  endproperty
  a_rate: assert property (p_rate) else $error("overshoot mode wrong");

endmodule : instr_status

//--- verification/serial_host.sv
// Host model on the serial link: drives the receive pin, takes transmitted bytes.
// Assumes the block samples the pin on clk and holds tx_byte until tx_ready.
`timescale 1ns/10ps
module serial_host (
  input wire logic clk,
  input wire logic slow,
  output logic pin_v,
  output logic [7:0] pin_b,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];
  initial begin
    pin_v = 1'b0;
    pin_b = 8'h00;
    tx_ready = 1'b1;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_byte);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // bytes incl. terminators and flow bytes.
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    pin_b <= b;
    pin_v <= 1'b1;
    repeat (4) @(posedge clk);
    pin_v <= 1'b0;
    repeat (4) @(posedge clk);
    pin_b <= ~b;
  endtask : send
endmodule : serial_host

//--- verification/instr_status_test.sv
// Bench for instr_status: status registers, serial lines, zero and rate.
// Assumes the serial host model sits on the pin and transmit sides.
`timescale 1ns/10ps
module instr_status_test;
  import instr_status_pkg::*;
  logic clk, rst, rd, wr, rq, eqn, lm, aset, zc, rc, rn, slow;
  cond_s cond;
  evt_s evt;
  reg_sel_e sel;
  logic [15:0] wd, rdat;
  logic srq, aen, remf, cv, ceol, cstd, rsv, rsl, rsr, txv, txr, zv, zs, ovl, pv;
  logic [7:0] cb, rsb, txb, pb;
  logic [8:0] cq[$];
  int n_errors = 0;
  int n_checks = 0;
  int n;
  instr_status #(.ZERO_DELAY_MS_P(3), .TICK_CYCLES_P(4)) dut_u (
    .clk(clk), .rst(rst), .cond(cond), .evt(evt), .resp_request(rq),
    .err_queue_nonempty(eqn), .reg_rd(rd), .reg_wr(wr), .reg_sel(sel),
    .reg_wdata(wd), .reg_rdata(rdat), .srq(srq), .legacy_mode(lm),
    .addressing_en_set(aset), .addressing_en(aen), .remote_flag(remf),
    .rx_pin_byte_valid(pv), .rx_pin_byte(pb), .cmd_byte(cb), .cmd_valid(cv),
    .cmd_eol(ceol), .cmd_standard(cstd), .resp_byte(rsb), .resp_valid(rsv),
    .resp_last(rsl), .resp_ready(rsr), .tx_byte(txb), .tx_valid(txv),
    .tx_ready(txr), .zero_cmd(zc), .zero_valve(zv), .zero_sensor(zs),
    .rate_cmd(rc), .rate_negative(rn), .overshoot_low(ovl));
  serial_host host_u (.clk(clk), .slow(slow), .pin_v(pv), .pin_b(pb),
    .tx_byte(txb), .tx_valid(txv), .tx_ready(txr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cv === 1'b1) begin
      cq.push_back({ceol, cb});
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input reg_sel_e s, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    sel <= s;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask : rdc
  task automatic wrr(input reg_sel_e s, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    sel <= s;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic waitq(input int k);
    n = 0;
    while (cq.size() < k && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({15'd0, n < 200}, 16'h0001);
  endtask : waitq
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #900_000;
    n_errors++;
    summarize();
  end
  initial begin
    {rst, rd, wr, rq, eqn, lm, aset, zc, rc, rn, slow, rsv, rsl} = 13'h1000;
    cond = '0;
    evt = '0;
    sel = REG_STATUS_BYTE;
    wd = 16'h0000;
    rsb = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
    rdc(REG_ESR, 16'h0084);
    rdc(REG_STATUS_BYTE, 16'h0000);
    @(posedge clk);
    cond <= '1;
    evt <= 5'h1E;
    @(posedge clk);
    evt <= '0;
    repeat (2) @(posedge clk);
    rdc(REG_OPERATION_GROUP_COND, 16'h4113);
    rdc(REG_QUESTIONABLE_GROUP_COND, 16'h018C);
    rdc(REG_OPERATION_EVENT, 16'h4113);
    rdc(REG_OPERATION_EVENT, 16'h0000);
    rdc(REG_QUESTIONABLE_EVENT, 16'h018C);
    rdc(REG_ESR, 16'h0039);
    @(posedge clk);
    cond <= '0;
    evt.param_ignored <= 1'b1;
    @(posedge clk);
    evt.param_ignored <= 1'b0;
    rdc(REG_OPERATION_GROUP_COND, 16'h0000);
    rdc(REG_QUESTIONABLE_EVENT, 16'h418C);
    rdc(REG_OPERATION_EVENT, 16'h4113);
    wrr(REG_OPERATION_ENABLE, 16'h0001);
    wrr(REG_SRE, 16'h0080);
    rdc(REG_SRE, 16'h0080);
    rdc(REG_STATUS_BYTE, 16'h0000);
    @(posedge clk);
    cond.calibrating <= 1'b1;
    eqn <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'd0, srq}, 16'h0001);
    rdc(REG_STATUS_BYTE, 16'h00C4);
    host_u.send(8'h41);
    host_u.send(CH_LF);
    host_u.send(8'h42);
    host_u.send(CH_CR);
    @(posedge clk);
    aset <= 1'b1;
    @(posedge clk);
    aset <= 1'b0;
    host_u.send(8'h43);
    host_u.send(CH_ETX);
    #1 chk({15'd0, aen}, 16'h0000);
    host_u.send(8'h44);
    waitq(5);
    chk({7'd0, cq[0]}, 16'h0041);
    chk({7'd0, cq[1]}, 16'h010A);
    chk({7'd0, cq[3]}, 16'h010D);
    chk({7'd0, cq[4]}, 16'h0044);
    host_u.send(CH_XOFF);
    slow <= 1'b1;
    rsb <= 8'h45;
    rsv <= 1'b1;
    rsl <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsr !== 1'b1 && n < 50);
    rsv <= 1'b0;
    chk({15'd0, n < 50}, 16'h0001);
    repeat (30) @(posedge clk);
    chk(16'(host_u.got.size()), 16'h0000);
    host_u.send(CH_XON);
    repeat (60) @(posedge clk);
    chk(16'(host_u.got.size()), 16'h0003);
    chk({8'd0, host_u.got[0]}, 16'h0045);
    chk({8'd0, host_u.got[1]}, 16'h000D);
    chk({8'd0, host_u.got[2]}, 16'h000A);
    lm <= 1'b1;
    @(posedge clk);
    #1 chk({15'd0, remf}, 16'h0001);
    host_u.send(CH_CR);
    host_u.send(8'h61);
    chk({15'd0, cstd}, 16'h0000);
    host_u.send(CH_SPACE);
    host_u.send(CH_CR);
    host_u.send(CH_COLON);
    waitq(9);
    chk({7'd0, cq[6]}, 16'h0041);
    chk({7'd0, cq[7]}, 16'h010D);
    chk({7'd0, cq[8]}, 16'h003A);
    chk({15'd0, cstd}, 16'h0001);
    @(posedge clk);
    zc <= 1'b1;
    @(posedge clk);
    zc <= 1'b0;
    @(posedge clk);
    #1 chk({15'd0, zv}, 16'h0001);
    n = 0;
    while (zs !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk({15'd0, zs}, 16'h0001);
    chk({15'd0, n >= 10 && n <= 16}, 16'h0001);
    @(posedge clk);
    cond.calibrating <= 1'b0;
    rdc(REG_OPERATION_GROUP_COND, 16'h0000);
    @(posedge clk);
    rn <= 1'b1;
    rc <= 1'b1;
    @(posedge clk);
    rc <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'd0, ovl}, 16'h0000);
    rn <= 1'b0;
    rc <= 1'b1;
    @(posedge clk);
    rc <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'd0, ovl}, 16'h0001);
    summarize();
  end
endmodule : instr_status_test
